// ===== rtl/serial_ctrl_cfg.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Control register N sits at 4*N, status register N at 0x80+4*N
`ifndef SERIAL_CTRL_CFG_SVH
`define SERIAL_CTRL_CFG_SVH
// ****************************************
// Map
// ****************************************
`define SR_BASE 8'h80
`define RXD_ADDR 8'hC0
`define TXD_ADDR 8'hC4
`define EOL_ADDR 8'hC8
`define CR_MASK 5'd1
`define CR_MODEM 5'd2
`define CR_BAUD 5'd3
`define CR_FMT 5'd4
`define CR_FEAT 5'd5
`define CR_DIVH 5'd6
`define CR_DIVL 5'd7
`define CR_ERRCH 5'd8
`define CR_TXRX 5'd9
`define CR_SKIP 5'd10
`define CR_INCTL 5'd11
`define CR_TERM1 5'd12
`define CR_EOLCFG 5'd16
`define CR_EOL1 5'd17
`define CR_LAST 5'd23
// ****************************************
// Reset values
// ****************************************
`define RST_TXRX 8'h89
`define RST_EOLCFG 8'h02
`define RST_EOL1 8'h0D
`define RST_EOL2 8'h0A
`define RST_FMT 8'h03
`define RST_DIVL 8'h01
// ****************************************
// Fields and timing
// ****************************************
`define TXRX_RXEN 0
`define TXRX_QRST 2
`define TXRX_SET7 3
`define TXRX_CHG 4
`define TXRX_NUL 5
`define TXRX_DEL 6
`define TXRX_TXEN 7
`define FEAT_RXHS 5
`define FMT_STOP2 2
`define FMT_PEN 3
`define FMT_EVEN 4
`define FMT_BRK 6
`define EOL_DIS 6
`define EOL_ARTS 7
`define EOL_MAX 6'd7
`define OSC_DIV_LAST 2'd2
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`endif

// ===== rtl/serial_ctrl_pkg.sv
// Purpose: Types of the serial controller
// Assumes: Constants live in serial_ctrl_cfg.svh
// Notes: State codes are one-hot
package serial_ctrl_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
        TX_PAR = 5'h08, TX_STOP = 5'h10
    } tx_state_t;
    typedef enum logic [4:0] {
        RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
        RX_PAR = 5'h08, RX_STOP = 5'h10
    } rx_state_t;
    typedef struct packed {
        logic [23:0][7:0] cr;
        logic [7:0] cause;
        logic [7:0] term;
        logic [7:0] rx_data;
        logic rx_pe;
        logic rx_fe;
        logic rx_brk;
        logic rx_avail;
        logic [7:0] tx_hold;
        logic tx_full;
        logic [5:0] eol_left;
        logic [2:0] eol_idx;
        logic [1:0] pre;
        logic [15:0] div;
        tx_state_t tx_st;
        logic [3:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [8:0] tx_sh;
        rx_state_t rx_st;
        logic [3:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_pbit;
        logic [2:0] mdm;
        logic strap_done;
        logic txd;
        logic rts;
        logic dtr;
        logic drs;
        logic irq;
        logic ack;
        logic [31:0] dat;
    } ctrl_state_t;
endpackage

// ===== rtl/serial_ctrl.sv
// Purpose: Serial interface controller with register bank and transceiver
// Assumes: 20 MHz clk_i, synchronous active-high reset, Wishbone classic
// Notes: Receive queue is a single holding entry read at RXD_ADDR
`timescale 1ns/1ps
`include "serial_ctrl_cfg.svh"
// Contract
// [RULE_01] Transceiver timing clock is the oscillator divided by three.
// [RULE_02] Twelve byte status registers and twenty-two byte control registers.
// [RULE_03] One byte-wide data lane carries both reads and writes; RXD_ADDR reads also return break, framing and parity flags in bits 10:8.
// [RULE_04] Software writes a control register to change operating state.
// [RULE_05] Status registers always reflect present state.
// [RULE_06] Receiver turns the serial stream into parallel bytes.
// [RULE_07] Transmitter turns parallel bytes into a serial stream.
// [RULE_08] Interrupt raised for each condition enabled in the mask.
// [RULE_09] Fixed behaviour; variables set by switches or software.
// [RULE_10] Received bytes dropped unless receiver enable bit is set.
// [RULE_11] With receive handshake on and carrier off, drop received data.
// [RULE_12] Parity or framing error is queued with the byte.
// [RULE_13] Line break queues a break indicator under the same conditions.
// [RULE_14] Control registers load defaults on reset; transceiver control 0x89.
// [RULE_15] EOL count picks stored EOL characters sent, unless disabled.
module serial_ctrl #(
    parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rxd_i,
    input wire logic cts_i,
    input wire logic dsr_i,
    input wire logic dcd_i,
    input wire logic [7:0] cfg_switch_i,
    output logic txd_o,
    output logic rts_o,
    output logic dtr_o,
    output logic drs_o,
    output logic irq_o
);
    import serial_ctrl_pkg::*;

    ctrl_state_t s_reg;
    ctrl_state_t s_next;

    function automatic logic [7:0] len_mask(input logic [1:0] len);
        return 8'hFF >> (2'd3 - len);
    endfunction

    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [7:0] fmt);
        logic p;
        p = ^(d & len_mask(fmt[1:0]));
        return fmt[`FMT_EVEN] ? p : ~p;
    endfunction

    function automatic logic cr_ok(input logic [4:0] i);
        return i != 5'd0 && i != `CR_SKIP && i <= `CR_LAST;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic req;
    logic wr;
    logic [4:0] idx;
    logic tick;
    logic [7:0] fmt;
    logic [7:0] txrx;
    logic [7:0] b;
    logic [7:0] set_c;
    logic [7:0] clr_c;
    logic [3:0] nbits;
    logic push;

    always_comb begin
        s_next = s_reg;
        req = wb_cyc_i && wb_stb_i && !s_reg.ack;
        wr = req && wb_we_i && wb_sel_i[0]; // see [RULE_03]
        idx = wb_adr_i[6:2];
        fmt = s_reg.cr[`CR_FMT];
        txrx = s_reg.cr[`CR_TXRX];
        nbits = 4'd5 + {2'b00, fmt[1:0]};
        set_c = 8'h00;
        clr_c = 8'h00;
        b = 8'h00;
        push = 1'b0;
        tick = 1'b0;

        // Prescaler by three, then baud divisor gives 16x ticks
        s_next.pre = (s_reg.pre == `OSC_DIV_LAST) ? 2'd0
                                                 : s_reg.pre + 2'd1;
        if (s_reg.pre == `OSC_DIV_LAST) begin // see [RULE_01]
            if (s_reg.div + 16'd1 >= {s_reg.cr[`CR_DIVH],
                                      s_reg.cr[`CR_DIVL]}) begin
                s_next.div = 16'd0;
                tick = 1'b1;
            end else begin
                s_next.div = s_reg.div + 16'd1;
            end
        end

        // Switches seed the baud number once after reset
        if (!s_reg.strap_done) begin // see [RULE_09]
            s_next.strap_done = 1'b1;
            s_next.cr[`CR_BAUD] = cfg_switch_i;
        end

        // Register bus
        s_next.ack = req;
        s_next.dat = 32'h0;
        if (req && !wb_we_i) begin
            if (!wb_adr_i[7]) begin
                if (cr_ok(idx)) begin
                    s_next.dat[7:0] = s_reg.cr[idx]; // see [RULE_02]
                end
            end else if (wb_adr_i == `RXD_ADDR) begin
                s_next.dat[10:0] = {s_reg.rx_brk, s_reg.rx_fe,
                                    s_reg.rx_pe, s_reg.rx_data};
                s_next.rx_avail = 1'b0;
            end else if (idx < 5'd12) begin
                case (idx) // see [RULE_05]
                    5'd0: s_next.dat[7:0] = ID_CODE;
                    5'd1: s_next.dat[7:0] = s_reg.cause;
                    5'd2: s_next.dat[7:0] = {5'h00,
                                             s_reg.cr[`CR_MODEM][2:0]};
                    5'd3: s_next.dat[7:0] = {4'h0, dcd_i, 1'b0,
                                             dsr_i, cts_i};
                    5'd10: s_next.dat[7:0] = {2'b00, !s_reg.tx_full,
                                              s_reg.rx_brk, s_reg.rx_fe,
                                              s_reg.rx_pe, 1'b0,
                                              s_reg.rx_avail};
                    5'd11: s_next.dat[7:0] = s_reg.term;
                    default: s_next.dat[7:0] = s_reg.cr[idx];
                endcase
            end
        end
        if (wr) begin
            if (!wb_adr_i[7] && cr_ok(idx)) begin
                s_next.cr[idx] = wb_dat_i[7:0]; // see [RULE_02]
            end
            if (wb_adr_i == `SR_BASE + 8'h04) begin
                clr_c = wb_dat_i[7:0];
            end
            if (wb_adr_i == `SR_BASE + 8'h2C) begin
                s_next.term = s_reg.term & ~wb_dat_i[7:0];
            end
            if (wb_adr_i == `TXD_ADDR && !s_reg.tx_full) begin
                s_next.tx_hold = wb_dat_i[7:0];
                s_next.tx_full = 1'b1;
            end
            if (wb_adr_i == {1'b0, `CR_TXRX, 2'b00} &&
                wb_dat_i[`TXRX_QRST]) begin
                s_next.rx_avail = 1'b0;
                s_next.cr[`CR_TXRX][`TXRX_QRST] = 1'b0;
            end
            if (wb_adr_i == `EOL_ADDR &&
                !s_reg.cr[`CR_EOLCFG][`EOL_DIS]) begin // see [RULE_15]
                s_next.eol_left =
                    (s_reg.cr[`CR_EOLCFG][5:0] > `EOL_MAX) ? `EOL_MAX
                    : s_reg.cr[`CR_EOLCFG][5:0];
                s_next.eol_idx = 3'd0;
            end
        end

        // Transmitter
        case (s_reg.tx_st) // see [RULE_07]
            TX_IDLE: begin
                if (txrx[`TXRX_TXEN] &&
                    (s_reg.tx_full || s_reg.eol_left != 6'd0)) begin
                    if (s_reg.tx_full) begin
                        b = s_reg.tx_hold;
                        s_next.tx_full = 1'b0;
                    end else begin
                        b = s_reg.cr[`CR_EOL1 + {2'b00, s_reg.eol_idx}];
                        s_next.eol_idx = s_reg.eol_idx + 3'd1;
                        s_next.eol_left = s_reg.eol_left - 6'd1;
                    end
                    s_next.tx_sh = {par_bit(b, fmt),
                                    b & len_mask(fmt[1:0])};
                    s_next.tx_cnt = 4'd0;
                    s_next.tx_bit = 4'd0;
                    s_next.tx_st = TX_START;
                end
            end
            default: begin
                if (tick) begin
                    s_next.tx_cnt = s_reg.tx_cnt + 4'd1;
                end
                if (tick && s_reg.tx_cnt == `OVS_LAST) begin
                    s_next.tx_bit = s_reg.tx_bit + 4'd1;
                    case (s_reg.tx_st)
                        TX_START: begin
                            s_next.tx_bit = 4'd0;
                            s_next.tx_st = TX_DATA;
                        end
                        TX_DATA: begin
                            if (s_reg.tx_bit + 4'd1 == nbits) begin
                                s_next.tx_bit = 4'd0;
                                s_next.tx_st = fmt[`FMT_PEN] ? TX_PAR
                                                             : TX_STOP;
                            end
                        end
                        TX_PAR: begin
                            s_next.tx_bit = 4'd0;
                            s_next.tx_st = TX_STOP;
                        end
                        default: begin
                            if (!fmt[`FMT_STOP2] ||
                                s_reg.tx_bit != 4'd0) begin
                                s_next.tx_st = TX_IDLE;
                            end
                        end
                    endcase
                end
            end
        endcase
        case (s_next.tx_st)
            TX_START: s_next.txd = 1'b0;
            TX_DATA: s_next.txd = s_next.tx_sh[s_next.tx_bit[2:0]];
            TX_PAR: s_next.txd = s_next.tx_sh[8];
            default: s_next.txd = 1'b1;
        endcase
        if (fmt[`FMT_BRK]) begin
            s_next.txd = 1'b0;
        end

        // Receiver, sampling mid-bit on 16x ticks
        if (tick) begin
            s_next.rx_cnt = s_reg.rx_cnt + 4'd1;
            case (s_reg.rx_st) // see [RULE_06]
                RX_IDLE: begin
                    s_next.rx_cnt = 4'd0;
                    if (!rxd_i) begin
                        s_next.rx_st = RX_START;
                    end
                end
                RX_START: begin
                    if (s_reg.rx_cnt == `OVS_MID) begin
                        s_next.rx_cnt = 4'd0;
                        s_next.rx_bit = 4'd0;
                        s_next.rx_sh = 8'h00;
                        s_next.rx_st = rxd_i ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (s_reg.rx_cnt == `OVS_LAST) begin
                        s_next.rx_sh[s_reg.rx_bit[2:0]] = rxd_i;
                        s_next.rx_bit = s_reg.rx_bit + 4'd1;
                        if (s_reg.rx_bit + 4'd1 == nbits) begin
                            s_next.rx_st = fmt[`FMT_PEN] ? RX_PAR
                                                         : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (s_reg.rx_cnt == `OVS_LAST) begin
                        s_next.rx_pbit = rxd_i;
                        s_next.rx_st = RX_STOP;
                    end
                end
                default: begin
                    if (s_reg.rx_cnt == `OVS_LAST) begin
                        s_next.rx_st = RX_IDLE;
                        push = 1'b1;
                    end
                end
            endcase
        end
        if (push) begin
            s_next.rx_fe = !rxd_i;
            s_next.rx_brk = !rxd_i && s_reg.rx_sh == 8'h00 &&
                            !s_reg.rx_pbit; // see [RULE_13]
            s_next.rx_pe = fmt[`FMT_PEN] && !s_next.rx_brk &&
                           s_reg.rx_pbit != par_bit(s_reg.rx_sh, fmt);
            b = s_next.rx_brk ? 8'h00 : s_reg.rx_sh;
            if (s_next.rx_pe || s_next.rx_fe) begin // see [RULE_12]
                if (txrx[`TXRX_CHG]) begin
                    b = s_reg.cr[`CR_ERRCH];
                end
                if (txrx[`TXRX_SET7]) begin
                    b[7] = 1'b1;
                end
            end
            if (!txrx[`TXRX_RXEN] ||
                (s_reg.cr[`CR_FEAT][`FEAT_RXHS] && !dcd_i) ||
                (!s_next.rx_brk && txrx[`TXRX_NUL] && b == 8'h00) ||
                (txrx[`TXRX_DEL] && b == 8'h7F)) begin
                // Dropped: keep the queued entry as it was
                s_next.rx_fe = s_reg.rx_fe; // see [RULE_10] [RULE_11]
                s_next.rx_brk = s_reg.rx_brk;
                s_next.rx_pe = s_reg.rx_pe;
            end else begin
                s_next.rx_data = b;
                s_next.rx_avail = 1'b1;
                set_c[7:4] = {s_next.rx_brk, s_next.rx_fe,
                              s_next.rx_pe, 1'b1};
                for (int i = 0; i < 4; i++) begin
                    if (s_reg.cr[`CR_INCTL][i + 1] &&
                        b == s_reg.cr[`CR_TERM1 + 5'(i)]) begin
                        s_next.term[i + 1] = 1'b1;
                    end
                end
            end
        end

        // Modem lines, interrupt causes and outputs
        s_next.mdm = {dcd_i, dsr_i, cts_i};
        set_c[3] = s_reg.mdm[2] ^ dcd_i;
        set_c[1:0] = s_reg.mdm[1:0] ^ {dsr_i, cts_i};
        // Set wins over a same-cycle write-one clear
        s_next.cause = (s_reg.cause & ~clr_c) | set_c;
        s_next.irq = |(s_next.cause & s_next.cr[`CR_MASK]); // see [RULE_08]
        s_next.dtr = s_next.cr[`CR_MODEM][0];
        s_next.rts = s_next.cr[`CR_MODEM][1] ||
                     (s_next.cr[`CR_EOLCFG][`EOL_ARTS] &&
                      s_next.tx_st != TX_IDLE);
        s_next.drs = s_next.cr[`CR_MODEM][2];

        if (rst_i) begin
            s_next = '0; // see [RULE_14]
            s_next.cr[`CR_FMT] = `RST_FMT;
            s_next.cr[`CR_DIVL] = `RST_DIVL;
            s_next.cr[`CR_TXRX] = `RST_TXRX;
            s_next.cr[`CR_EOLCFG] = `RST_EOLCFG;
            s_next.cr[`CR_EOL1] = `RST_EOL1;
            s_next.cr[`CR_EOL1 + 5'd1] = `RST_EOL2;
            s_next.tx_st = TX_IDLE;
            s_next.rx_st = RX_IDLE;
            s_next.txd = 1'b1;
            s_next.mdm = {dcd_i, dsr_i, cts_i};
        end
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.dat;
    assign txd_o = s_reg.txd;
    assign rts_o = s_reg.rts;
    assign dtr_o = s_reg.dtr;
    assign drs_o = s_reg.drs;
    assign irq_o = s_reg.irq;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_PRESCALE: assert property ( // see [RULE_01]
        s_reg.pre == 2'd0 |=> s_reg.pre == 2'd1 ##1 s_reg.pre == 2'd2
            ##1 s_reg.pre == 2'd0)
        else $error("prescaler is not divide by three");
    AST_CR_WRITE: assert property ( // see [RULE_02]
        wr && !wb_adr_i[7] && cr_ok(idx) && idx != `CR_TXRX
        |=> s_reg.cr[$past(idx)] == $past(wb_dat_i[7:0]))
        else $error("control register write lost");
    AST_ACK: assert property ( // see [RULE_03]
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");
    AST_TX_START: assert property ( // see [RULE_07]
        s_reg.tx_st == TX_IDLE && s_next.tx_st == TX_START &&
        !fmt[`FMT_BRK] |=> ##1 !txd_o)
        else $error("start bit not sent");
    AST_IRQ: assert property ( // see [RULE_08]
        (s_reg.cause & s_reg.cr[`CR_MASK]) != 8'h00 && clr_c == 8'h00
        && !wr |=> irq_o)
        else $error("enabled cause did not interrupt");
    AST_RX_OFF: assert property ( // see [RULE_10]
        push && !txrx[`TXRX_RXEN] && !s_reg.rx_avail |=> !s_reg.rx_avail)
        else $error("byte queued with receiver off");
    AST_RX_HS: assert property ( // see [RULE_11]
        push && s_reg.cr[`CR_FEAT][`FEAT_RXHS] && !dcd_i &&
        !s_reg.rx_avail |=> !s_reg.rx_avail)
        else $error("byte queued with carrier off");
    AST_RST: assert property ( // see [RULE_14]
        $fell(rst_i) |-> s_reg.cr[`CR_TXRX] == `RST_TXRX &&
        s_reg.cr[`CR_EOLCFG] == `RST_EOLCFG)
        else $error("control defaults wrong after reset");
    AST_EOL_OFF: assert property ( // see [RULE_15]
        wr && wb_adr_i == `EOL_ADDR && s_reg.cr[`CR_EOLCFG][`EOL_DIS] &&
        s_reg.eol_left == 6'd0 |=> s_reg.eol_left == 6'd0)
        else $error("EOL sent while disabled");
endmodule // serial_ctrl

// ===== test/remote_serial_model.sv
// Purpose: Remote serial device facing the controller's serial link
// Assumes: 8 data bits, no parity, one stop bit, line idles high
// Notes: Bit time in clocks is a parameter; low stop only on command
`timescale 1ns/1ps
module remote_serial_model #(
    parameter int BIT_CLKS = 48
) (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic send_i,
    input wire logic [7:0] send_byte_i,
    input wire logic bad_stop_i,
    output logic rxd_o,
    output logic [7:0] heard_o,
    output logic heard_stb_o
);
    logic [9:0] frame;
    logic [7:0] shreg;
    initial begin
        rxd_o = 1'h1;
        forever begin
            @(posedge clk_i);
            if (send_i === 1'h1) begin
                // Stop, data LSB first, start
                frame = {~bad_stop_i, send_byte_i, 1'h0};
                for (int i = 0; i < 10; i++) begin
                    rxd_o <= frame[i];
                    repeat (BIT_CLKS) @(posedge clk_i);
                end
                rxd_o <= 1'h1;
            end
        end
    end
    initial begin
        heard_o = 8'h00;
        heard_stb_o = 1'h0;
        forever begin
            @(posedge clk_i);
            heard_stb_o <= 1'h0;
            if (txd_i === 1'h0) begin
                // Sample mid-bit so small rate slips still decode
                repeat (BIT_CLKS / 2) @(posedge clk_i);
                for (int j = 0; j < 8; j++) begin
                    repeat (BIT_CLKS) @(posedge clk_i);
                    shreg[j] = txd_i;
                end
                repeat (BIT_CLKS) @(posedge clk_i);
                heard_o <= shreg;
                heard_stb_o <= txd_i;
            end
        end
    end
endmodule // remote_serial_model

// ===== test/serial_interface_controller_config_test.sv
// Purpose: Self-checking bench of the serial controller
// Assumes: Default 48-clock bit time and 8N1 line format
// Notes: Register table first, then receive, transmit and reset cases
`timescale 1ns/1ps
module serial_interface_controller_config_test;
    localparam logic [7:0] ID = 8'h3C; // Arbitrary value
    typedef struct packed {
        logic [7:0] adr;
        logic we;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_t;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rxd_i;
    logic dcd_i, txd_o, rts_o, dtr_o, drs_o, irq_o, send_i, bad_stop;
    logic heard_stb;
    logic [7:0] wb_adr_i, send_byte, heard;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    int n_errors = 0;
    int cmp_count = 0;
    row_t rows [12] = '{'{8'h24, 1'h0, 8'h00, 8'h89},
        '{8'h40, 1'h0, 8'h00, 8'h02}, '{8'h44, 1'h0, 8'h00, 8'h0D},
        '{8'h48, 1'h0, 8'h00, 8'h0A}, '{8'h30, 1'h0, 8'h00, 8'h00},
        '{8'h80, 1'h0, 8'h00, ID}, '{8'h90, 1'h0, 8'h00, 8'h03},
        '{8'h30, 1'h1, 8'hA5, 8'hA5}, '{8'h5C, 1'h1, 8'h3C, 8'h3C},
        '{8'h28, 1'h1, 8'h55, 8'h00}, '{8'hA4, 1'h1, 8'h00, 8'h89},
        '{8'h20, 1'h1, 8'hC3, 8'hC3}};
    serial_ctrl #(.ID_CODE(ID)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i),
        .cts_i(1'h0), .dsr_i(1'h0), .dcd_i(dcd_i), .cfg_switch_i(8'h00),
        .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o), .drs_o(drs_o),
        .irq_o(irq_o));
    remote_serial_model #(.BIT_CLKS(48)) far (.clk_i(clk_i),
        .txd_i(txd_o), .send_i(send_i), .send_byte_i(send_byte),
        .bad_stop_i(bad_stop), .rxd_o(rxd_i), .heard_o(heard),
        .heard_stb_o(heard_stb));
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic we,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1) begin
            n_errors++;
            $display("BAD %0t no bus answer", $time);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        wb_sel_i <= 4'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(a, 1'h1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'h0, 8'h00, q);
        check(q, e);
    endtask
    // Frame takes 480 clocks; 600 leaves room for the store
    task automatic send(input logic [7:0] b, input logic bad);
        @(posedge clk_i);
        send_i <= 1'h1;
        send_byte <= b;
        bad_stop <= bad;
        @(posedge clk_i);
        send_i <= 1'h0;
        repeat (600) @(posedge clk_i);
    endtask
    task automatic hear(input logic [7:0] e);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (heard_stb !== 1'h1 && n < 1500);
        check({23'h0, heard_stb, heard}, {23'h0, 1'h1, e});
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        n_errors++;
        summarize();
    end
    initial begin
        int n;
        {wb_cyc_i, wb_stb_i, wb_we_i, send_i, bad_stop, dcd_i} = 6'h0;
        {wb_adr_i, send_byte, wb_sel_i, wb_dat_i} = 52'h0;
        rst_i = 1'h1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        foreach (rows[i]) begin
            if (rows[i].we === 1'h1) begin
                wr(rows[i].adr, rows[i].wd);
            end
            rd(rows[i].adr, {24'h0, rows[i].exp});
        end
        $display("test registers done");
        wr(8'h04, 8'h10);
        send(8'h3C, 1'h0);
        check({31'h0, irq_o}, 32'h1);
        rd(8'h84, 32'h10);
        rd(8'hC0, 32'h03C);
        wr(8'h84, 8'h10);
        repeat (3) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wr(8'h24, 8'h88);
        send(8'h55, 1'h0);
        rd(8'hA8, 32'h20);
        wr(8'h24, 8'h89);
        wr(8'h14, 8'h20);
        send(8'h66, 1'h0);
        rd(8'hA8, 32'h20);
        dcd_i <= 1'h1;
        repeat (10) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(8'h84, 32'h08);
        send(8'h66, 1'h0);
        rd(8'hC0, 32'h066);
        send(8'h11, 1'h1);
        rd(8'hC0, 32'h291);
        // Break counts as a framing error, so bit seven is set too
        send(8'h00, 1'h1);
        rd(8'hC0, 32'h680);
        $display("test receive done");
        wr(8'hC4, 8'hA7);
        hear(8'hA7);
        wr(8'hC8, 8'h00);
        hear(8'h0D);
        hear(8'h0A);
        wr(8'h40, 8'h42);
        wr(8'hC8, 8'h00);
        n = 0;
        repeat (700) begin
            @(posedge clk_i);
            if (heard_stb === 1'h1) n++;
        end
        check(n, 0);
        wr(8'h08, 8'h07);
        repeat (3) @(posedge clk_i);
        check({29'h0, drs_o, rts_o, dtr_o}, 32'h7);
        $display("test transmit done");
        rst_i <= 1'h1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        check({30'h0, txd_o, irq_o}, 32'h2);
        for (int i = 0; i < 5; i++) begin
            rd(rows[i].adr, {24'h0, rows[i].exp});
        end
        $display("test reset done");
        summarize();
    end
endmodule // serial_interface_controller_config_test
